// ---- verilog/bank1_regs_pkg.sv ----
package bank1_regs_pkg;

  // Register indices; the APB byte address is four times the index
  localparam logic [7:0] IDX_INDIRECT_DATA_PORT = 8'h80;
  localparam logic [7:0] IDX_OPTION_SETTINGS = 8'h81;
  localparam logic [7:0] IDX_PROGRAM_COUNTER_LOW = 8'h82;
  localparam logic [7:0] IDX_CORE_STATUS = 8'h83;
  localparam logic [7:0] IDX_INDIRECT_POINTER = 8'h84;
  localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h86;
  localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h87;
  localparam logic [7:0] IDX_PROGRAM_COUNTER_HIGH_LATCH = 8'h8a;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h8b;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLE = 8'h8c;
  localparam logic [7:0] IDX_POWER_RESET_CAUSE = 8'h8e;
  localparam logic [7:0] IDX_TIMER2_PERIOD = 8'h92;
  localparam logic [7:0] IDX_SERIAL_PORT_SLAVE_ADDRESS = 8'h93;
  localparam logic [7:0] IDX_SERIAL_PORT_STATE = 8'h94;
  // Bit 7 of the index is the bank bit that the mirrored registers ignore
  localparam int BANK_BIT = 7;

  // Reset values
  localparam logic [7:0] RST_OPTION_SETTINGS = 8'hff;
  localparam logic [5:0] RST_PORT_A_DIRECTION = 6'h3f;
  localparam logic [7:0] RST_PORT_B_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PORT_C_DIRECTION = 8'hff;
  localparam logic [7:0] RST_TIMER2_PERIOD = 8'hff;
  localparam logic [7:0] RST_SERIAL_PORT_SLAVE_ADDRESS = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLE = 8'h00;
  localparam logic [4:0] RST_PROGRAM_COUNTER_HIGH_LATCH = 5'h00;
  localparam logic [12:0] RST_PROGRAM_COUNTER = 13'h0000;
  localparam logic [7:0] RST_INDIRECT_POINTER = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [5:0] RST_SERIAL_PORT_STATE = 6'h00;

  // Field widths
  localparam int HIGH_LATCH_W = 5;
  localparam int PORT_A_W = 6;
  localparam int SSP_STATE_W = 6;
  localparam int IRQ_FLAG_W = 3;

  typedef struct packed {
    logic indirect_bank_select;
    logic direct_bank_select_high;
    logic direct_bank_select_low;
    logic timeout_b;
    logic power_down_b;
    logic zero;
    logic digit_carry;
    logic carry;
  } core_status_t;

  localparam core_status_t RST_CORE_STATUS = 8'h18;

  typedef struct packed {
    logic power_on_flag_b;
    logic brownout_flag;
  } reset_cause_t;

  // After power-on: power-on flag low, brown-out flag high (no brown-out)
  localparam reset_cause_t RST_POWER_RESET_CAUSE = 2'h1;

  typedef enum logic [1:0] {
    RST_NONE = 2'b00,
    RST_POWER = 2'b01,
    RST_BROWNOUT = 2'b10,
    RST_OTHER = 2'b11
  } reset_kind_t;

endpackage

// ---- verilog/bank1_special_register_map.sv ----
`timescale 1ns/10ps

// Summary of operation
// - An unimplemented bank 1 location reads as zero and ignores writes.
// - The mirrored core registers answer at both bank 0 and bank 1 offsets.
// - Program counter bits 12 to 8 are reachable only through the latch.
// - The 5-bit latch is copied into the counter top bits on every load.
// - Power-on and brown-out apply one reset set, pin and watchdog another.
module bank1_special_register_map
  import bank1_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  // Reset sources
  input wire logic external_reset_pin_b_i,
  input wire logic brownout_i,
  input wire logic watchdog_timeout_i,
  // Core side
  input wire logic pc_advance_i,
  input wire logic pc_load_i,
  input wire logic [7:0] pc_load_low_i,
  input wire logic alu_flags_we_i,
  input wire logic [2:0] alu_flags_i,
  input wire logic sleep_entry_i,
  input wire logic [IRQ_FLAG_W-1:0] irq_flag_set_i,
  input wire logic [7:0] indirect_data_i,
  input wire logic [SSP_STATE_W-1:0] serial_port_state_i,
  output logic [12:0] program_counter_o,
  output logic [7:0] indirect_pointer_o,
  output logic indirect_write_o,
  output logic [7:0] indirect_wdata_o,
  output core_status_t core_status_o,
  output logic [7:0] option_settings_o,
  output logic [PORT_A_W-1:0] port_a_direction_o,
  output logic [7:0] port_b_direction_o,
  output logic [7:0] port_c_direction_o,
  output logic [7:0] interrupt_control_o,
  output logic [7:0] peripheral_irq_enable_o,
  output logic [7:0] timer2_period_o,
  output logic [7:0] serial_port_slave_address_o
);

  logic ext_meta_q;
  logic ext_sync_q;
  logic bo_meta_q;
  logic bo_sync_q;
  reset_kind_t reset_kind;

  logic [7:0] idx;
  logic setup;
  logic wr_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic mirrored;
  logic [7:0] core_idx;

  logic [7:0] option_settings_q;
  logic [PORT_A_W-1:0] port_a_direction_q;
  logic [7:0] port_b_direction_q;
  logic [7:0] port_c_direction_q;
  logic [HIGH_LATCH_W-1:0] program_counter_high_latch_q;
  logic [12:0] program_counter_q;
  core_status_t core_status_q;
  logic [7:0] indirect_pointer_q;
  logic [7:0] interrupt_control_q;
  logic [7:0] peripheral_irq_enable_q;
  reset_cause_t power_reset_cause_q;
  logic [7:0] timer2_period_q;
  logic [7:0] serial_port_slave_address_q;
  logic [SSP_STATE_W-1:0] serial_port_state_q;
  logic indirect_write_q;
  logic [7:0] indirect_wdata_q;
  logic [31:0] prdata_q;
  logic pready_q;

  // Pin inputs pass two flip-flops before anything looks at them
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_meta_q <= 1'b1;
      ext_sync_q <= 1'b1;
      bo_meta_q <= 1'b0;
      bo_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= external_reset_pin_b_i;
      ext_sync_q <= ext_meta_q;
      bo_meta_q <= brownout_i;
      bo_sync_q <= bo_meta_q;
    end
  end

  // Brown-out outranks the pin and the watchdog; power-on is rst_b_i itself
  always_comb begin
    if (bo_sync_q) begin
      reset_kind = RST_BROWNOUT;
    end else if (!ext_sync_q || watchdog_timeout_i) begin
      reset_kind = RST_OTHER;
    end else begin
      reset_kind = RST_NONE;
    end
  end

  // APB decode; every access has one wait-free access phase
  assign idx = paddr[9:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite &&
                 reset_kind == RST_NONE;
  assign wdata = pwdata[7:0];

  // Core registers ignore the bank bit so either bank reaches them
  always_comb begin
    case (idx & ~(8'h01 << BANK_BIT))
      IDX_INDIRECT_DATA_PORT & 8'h7f,
      IDX_PROGRAM_COUNTER_LOW & 8'h7f,
      IDX_CORE_STATUS & 8'h7f,
      IDX_INDIRECT_POINTER & 8'h7f,
      IDX_PROGRAM_COUNTER_HIGH_LATCH & 8'h7f,
      IDX_INTERRUPT_CONTROL & 8'h7f: begin
        mirrored = 1'b1;
      end
      default: begin
        mirrored = 1'b0;
      end
    endcase
  end

  assign core_idx = mirrored ? (idx | (8'h01 << BANK_BIT)) : idx;

  always_comb begin
    rdata = 8'h00;
    case (core_idx)
      IDX_INDIRECT_DATA_PORT: rdata = indirect_data_i;
      IDX_OPTION_SETTINGS: rdata = option_settings_q;
      IDX_PROGRAM_COUNTER_LOW: rdata = program_counter_q[7:0];
      IDX_CORE_STATUS: rdata = core_status_q;
      IDX_INDIRECT_POINTER: rdata = indirect_pointer_q;
      IDX_PORT_A_DIRECTION: rdata = {2'b00, port_a_direction_q};
      IDX_PORT_B_DIRECTION: rdata = port_b_direction_q;
      IDX_PORT_C_DIRECTION: rdata = port_c_direction_q;
      IDX_PROGRAM_COUNTER_HIGH_LATCH: begin
        rdata = {3'b000, program_counter_high_latch_q};
      end
      IDX_INTERRUPT_CONTROL: rdata = interrupt_control_q;
      IDX_PERIPHERAL_IRQ_ENABLE: rdata = peripheral_irq_enable_q;
      IDX_POWER_RESET_CAUSE: rdata = {6'h00, power_reset_cause_q};
      IDX_TIMER2_PERIOD: rdata = timer2_period_q;
      IDX_SERIAL_PORT_SLAVE_ADDRESS: rdata = serial_port_slave_address_q;
      IDX_SERIAL_PORT_STATE: rdata = {2'b00, serial_port_state_q};
      default: rdata = 8'h00;
    endcase
  end

  // Read data is caught in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= {24'h00_0000, rdata};
      end
    end
  end

  // Registers that every reset set loads with the same value
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      option_settings_q <= RST_OPTION_SETTINGS;
      port_a_direction_q <= RST_PORT_A_DIRECTION;
      port_b_direction_q <= RST_PORT_B_DIRECTION;
      port_c_direction_q <= RST_PORT_C_DIRECTION;
      timer2_period_q <= RST_TIMER2_PERIOD;
      serial_port_slave_address_q <= RST_SERIAL_PORT_SLAVE_ADDRESS;
      peripheral_irq_enable_q <= RST_PERIPHERAL_IRQ_ENABLE;
      program_counter_high_latch_q <= RST_PROGRAM_COUNTER_HIGH_LATCH;
    end else if (reset_kind != RST_NONE) begin
      option_settings_q <= RST_OPTION_SETTINGS;
      port_a_direction_q <= RST_PORT_A_DIRECTION;
      port_b_direction_q <= RST_PORT_B_DIRECTION;
      port_c_direction_q <= RST_PORT_C_DIRECTION;
      timer2_period_q <= RST_TIMER2_PERIOD;
      serial_port_slave_address_q <= RST_SERIAL_PORT_SLAVE_ADDRESS;
      peripheral_irq_enable_q <= RST_PERIPHERAL_IRQ_ENABLE;
      program_counter_high_latch_q <= RST_PROGRAM_COUNTER_HIGH_LATCH;
    end else if (wr_en) begin
      case (core_idx)
        IDX_OPTION_SETTINGS: option_settings_q <= wdata;
        IDX_PORT_A_DIRECTION: port_a_direction_q <= wdata[PORT_A_W-1:0];
        IDX_PORT_B_DIRECTION: port_b_direction_q <= wdata;
        IDX_PORT_C_DIRECTION: port_c_direction_q <= wdata;
        IDX_TIMER2_PERIOD: timer2_period_q <= wdata;
        IDX_SERIAL_PORT_SLAVE_ADDRESS: serial_port_slave_address_q <= wdata;
        // Bits 7:6 are stored as written; small parts rely on software
        IDX_PERIPHERAL_IRQ_ENABLE: peripheral_irq_enable_q <= wdata;
        IDX_PROGRAM_COUNTER_HIGH_LATCH: begin
          // Holds between loads; only this write or a reset changes it
          program_counter_high_latch_q <= wdata[HIGH_LATCH_W-1:0];
        end
        default: option_settings_q <= option_settings_q;
      endcase
    end
  end

  // Program counter: every load takes its top bits from the latch
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      program_counter_q <= RST_PROGRAM_COUNTER;
    end else if (reset_kind != RST_NONE) begin
      program_counter_q <= RST_PROGRAM_COUNTER;
    end else if (wr_en && core_idx == IDX_PROGRAM_COUNTER_LOW) begin
      program_counter_q <= {program_counter_high_latch_q, wdata};
    end else if (pc_load_i) begin
      program_counter_q <= {program_counter_high_latch_q, pc_load_low_i};
    end else if (pc_advance_i) begin
      program_counter_q <= program_counter_q + 13'h0001;
    end
  end

  // Core status: the bank bits and arithmetic flags are writable,
  // the timeout and power-down bits follow reset and sleep only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      core_status_q <= RST_CORE_STATUS;
    end else if (reset_kind == RST_BROWNOUT) begin
      core_status_q <= RST_CORE_STATUS;
    end else if (reset_kind == RST_OTHER) begin
      core_status_q.indirect_bank_select <= 1'b0;
      core_status_q.direct_bank_select_high <= 1'b0;
      core_status_q.direct_bank_select_low <= 1'b0;
      if (watchdog_timeout_i) begin
        core_status_q.timeout_b <= 1'b0;
      end
    end else begin
      if (wr_en && core_idx == IDX_CORE_STATUS) begin
        // Bank bits stored as written; small parts rely on software
        core_status_q.indirect_bank_select <= wdata[7];
        core_status_q.direct_bank_select_high <= wdata[6];
        core_status_q.direct_bank_select_low <= wdata[5];
        core_status_q.zero <= wdata[2];
        core_status_q.digit_carry <= wdata[1];
        core_status_q.carry <= wdata[0];
      end
      // The ALU result wins over a software write in the same cycle
      if (alu_flags_we_i) begin
        core_status_q.zero <= alu_flags_i[2];
        core_status_q.digit_carry <= alu_flags_i[1];
        core_status_q.carry <= alu_flags_i[0];
      end
      if (sleep_entry_i) begin
        core_status_q.timeout_b <= 1'b1;
        core_status_q.power_down_b <= 1'b0;
      end
    end
  end

  // Indirect pointer keeps contents on other resets; interrupt control keeps only bit 0
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      indirect_pointer_q <= RST_INDIRECT_POINTER;
    end else if (reset_kind == RST_BROWNOUT) begin
      indirect_pointer_q <= RST_INDIRECT_POINTER;
    end else if (wr_en && core_idx == IDX_INDIRECT_POINTER) begin
      indirect_pointer_q <= wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interrupt_control_q <= RST_INTERRUPT_CONTROL;
    end else if (reset_kind == RST_BROWNOUT) begin
      interrupt_control_q <= RST_INTERRUPT_CONTROL;
    end else if (reset_kind == RST_OTHER) begin
      // Bit 0 is left alone on pin and watchdog resets
      interrupt_control_q[7:1] <= RST_INTERRUPT_CONTROL[7:1];
    end else begin
      if (wr_en && core_idx == IDX_INTERRUPT_CONTROL) begin
        interrupt_control_q <= wdata;
      end
      // Hardware flag set wins over a software clear in the same cycle
      for (int i = 0; i < IRQ_FLAG_W; i++) begin
        if (irq_flag_set_i[i]) begin
          interrupt_control_q[i] <= 1'b1;
        end
      end
    end
  end

  // Reset cause: power-on flag clears on power-on only,
  // brown-out flag clears on brown-out; software sets them back
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_reset_cause_q <= RST_POWER_RESET_CAUSE;
    end else if (reset_kind == RST_BROWNOUT) begin
      power_reset_cause_q.brownout_flag <= 1'b0;
    end else if (reset_kind == RST_NONE && wr_en &&
                 core_idx == IDX_POWER_RESET_CAUSE) begin
      // Where the brown-out bit is reserved, software keeps it at one
      power_reset_cause_q <= wdata[1:0];
    end
  end

  // Serial port state is read-only here; it mirrors the port's flags
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_port_state_q <= RST_SERIAL_PORT_STATE;
    end else if (reset_kind != RST_NONE) begin
      serial_port_state_q <= RST_SERIAL_PORT_STATE;
    end else begin
      serial_port_state_q <= serial_port_state_i;
    end
  end

  // A write to the indirect data port is handed to data memory
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      indirect_write_q <= 1'b0;
      indirect_wdata_q <= 8'h00;
    end else begin
      indirect_write_q <= wr_en && core_idx == IDX_INDIRECT_DATA_PORT;
      if (wr_en && core_idx == IDX_INDIRECT_DATA_PORT) begin
        indirect_wdata_q <= wdata;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign program_counter_o = program_counter_q;
  assign indirect_pointer_o = indirect_pointer_q;
  assign indirect_write_o = indirect_write_q;
  assign indirect_wdata_o = indirect_wdata_q;
  assign core_status_o = core_status_q;
  assign option_settings_o = option_settings_q;
  assign port_a_direction_o = port_a_direction_q;
  assign port_b_direction_o = port_b_direction_q;
  assign port_c_direction_o = port_c_direction_q;
  assign interrupt_control_o = interrupt_control_q;
  assign peripheral_irq_enable_o = peripheral_irq_enable_q;
  assign timer2_period_o = timer2_period_q;
  assign serial_port_slave_address_o = serial_port_slave_address_q;

endmodule

// ---- sim/bank1_map_assertions.sv ----
`timescale 1ns/10ps
module bank1_map_checker
  import bank1_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic external_reset_pin_b_i,
  input wire logic brownout_i,
  input wire logic watchdog_timeout_i,
  input wire logic pc_advance_i,
  input wire logic pc_load_i,
  input wire logic [7:0] pc_load_low_i,
  input wire logic [12:0] program_counter_o,
  input wire logic [7:0] indirect_pointer_o,
  input wire logic indirect_write_o,
  input wire logic [7:0] indirect_wdata_o,
  input wire core_status_t core_status_o,
  input wire logic [7:0] option_settings_o,
  input wire logic [PORT_A_W-1:0] port_a_direction_o
);
  logic [3:0] calm_q;
  logic [7:0] idx;
  logic unm;
  logic ok;
  logic wr_acc;
  assign idx = paddr[9:2];
  assign unm = idx inside {8'h88, 8'h89, 8'h8d, 8'h8f, 8'h90, 8'h91}
    || idx > 8'h94;
  assign ok = calm_q > 4'h5 && external_reset_pin_b_i && !brownout_i
    && !watchdog_timeout_i;
  assign wr_acc = psel && penable && pready && pwrite && ok;
  // Pin and brown-out sources pass a synchroniser, so stay quiet for a while after any reset source
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      calm_q <= 4'h0;
    end else if (!ok && calm_q > 4'h5) begin
      calm_q <= 4'h0;
    end else if (!external_reset_pin_b_i || brownout_i ||
                 watchdog_timeout_i) begin
      calm_q <= 4'h0;
    end else if (calm_q != 4'hf) begin
      calm_q <= calm_q + 4'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_setup; psel && !penable; endsequence
  sequence s_pcl_wr; wr_acc && idx[6:0] == 7'h02; endsequence
  property p_answer; s_setup |=> pready ##1 !pready; endproperty
  property p_upper; pready |-> prdata[31:8] == 24'h00_0000; endproperty
  property p_unmapped;
    s_setup ##0 (!pwrite && unm) |=> prdata == 32'h0000_0000;
  endproperty
  property p_mirror;
    wr_acc && idx[6:0] == 7'h04 |=> indirect_pointer_o == $past(pwdata[7:0]);
  endproperty
  property p_indirect;
    wr_acc && idx[6:0] == 7'h00 |=> indirect_write_o
      && indirect_wdata_o == $past(pwdata[7:0]);
  endproperty
  property p_pcl; s_pcl_wr |=> program_counter_o[7:0] == $past(pwdata[7:0]);
  endproperty
  property p_load;
    ok && pc_load_i && !wr_acc |=>
      program_counter_o[7:0] == $past(pc_load_low_i);
  endproperty
  property p_hold;
    ok && !pc_load_i && !pc_advance_i && !wr_acc |=>
      $stable(program_counter_o);
  endproperty
  property p_por;
    !$past(rst_b_i) |-> option_settings_o == 8'hff
      && core_status_o == RST_CORE_STATUS && port_a_direction_o == 6'h3f;
  endproperty
  property p_wdog;
    watchdog_timeout_i |-> ##[1:4] (!core_status_o.timeout_b
      && option_settings_o == 8'hff);
  endproperty
  a_answer: assert property (p_answer) else $error("no one-cycle answer");
  a_upper: assert property (p_upper) else $error("upper read bits set");
  a_unmapped: assert property (p_unmapped) else $error("hole not zero");
  a_mirror: assert property (p_mirror) else $error("pointer mirror");
  a_indirect: assert property (p_indirect) else $error("indirect write");
  a_pcl: assert property (p_pcl) else $error("counter low write");
  a_load: assert property (p_load) else $error("counter load");
  a_hold: assert property (p_hold) else $error("counter moved");
  a_por: assert property (p_por) else $error("power-on values");
  a_wdog: assert property (p_wdog) else $error("watchdog reset");
endmodule

bind bank1_special_register_map bank1_map_checker checker_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .external_reset_pin_b_i(external_reset_pin_b_i),
  .brownout_i(brownout_i), .watchdog_timeout_i(watchdog_timeout_i),
  .pc_advance_i(pc_advance_i), .pc_load_i(pc_load_i),
  .pc_load_low_i(pc_load_low_i), .program_counter_o(program_counter_o),
  .indirect_pointer_o(indirect_pointer_o),
  .indirect_write_o(indirect_write_o), .indirect_wdata_o(indirect_wdata_o),
  .core_status_o(core_status_o), .option_settings_o(option_settings_o),
  .port_a_direction_o(port_a_direction_o));

// ---- sim/test_bank1_special_register_map.sv ----
`timescale 1ns/10ps
module test_bank1_special_register_map;
  import bank1_regs_pkg::*;
  logic clk_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h3394;
  logic pready, ext_b = 1, bo = 0, wd = 0, adv = 0, ld = 0, iw, sl = 0;
  logic [7:0] lo = '0, idata = 8'h5a, ptr, iwd, opt, m [0:255], wm [0:255];
  logic [2:0] irq = '0;
  logic [5:0] ssp = 6'h2b, pa;
  logic [12:0] pcv, pc;
  logic [7:0] pb, pcc, ic, pie, pr, sa;
  core_status_t st;
  int fail_count = 0, checks = 0;
  always #10 clk_i = ~clk_i;
  bank1_special_register_map bank1_special_register_map_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .external_reset_pin_b_i(ext_b), .brownout_i(bo),
    .watchdog_timeout_i(wd), .pc_advance_i(adv), .pc_load_i(ld),
    .pc_load_low_i(lo), .alu_flags_we_i(1'b0), .alu_flags_i(3'h0),
    .sleep_entry_i(sl), .irq_flag_set_i(irq), .indirect_data_i(idata),
    .serial_port_state_i(ssp), .program_counter_o(pcv),
    .indirect_pointer_o(ptr), .indirect_write_o(iw),
    .indirect_wdata_o(iwd), .core_status_o(st), .option_settings_o(opt),
    .port_a_direction_o(pa), .port_b_direction_o(pb),
    .port_c_direction_o(pcc), .interrupt_control_o(ic),
    .peripheral_irq_enable_o(pie), .timer2_period_o(pr),
    .serial_port_slave_address_o(sa));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] ix(logic [7:0] a);
    if (a inside {8'h00, 8'h02, 8'h03, 8'h04, 8'h0a, 8'h0b}) return a | 8'h80;
    return a;
  endfunction
  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] r);
    int n;
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= {a, 2'b00}; pwdata <= {24'h00_0000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 16);
    r = prdata;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 16) begin fail_count++; close_out(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic [7:0] i;
    apb(1'b1, a, d, r);
    i = ix(a);
    if (i == 8'h82) pc = {m[8'h8a][4:0], d};
    else m[i] = (m[i] & ~wm[i]) | (d & wm[i]);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] r;
    logic [7:0] i, e;
    apb(1'b0, a, 8'h00, r);
    i = ix(a);
    e = i == 8'h80 ? idata : i == 8'h82 ? pc[7:0] :
        i == 8'h94 ? {2'b00, ssp} : m[i];
    chk(r, {24'h00_0000, e});
  endtask
  task automatic rdall();
    for (int i = 128; i < 160; i++) rd(i[7:0]);
    chk(pcv, pc);
    chk(opt, m[8'h81]); chk(pa, m[8'h85]); chk(pb, m[8'h86]);
    chk(pcc, m[8'h87]); chk(ic, m[8'h8b]); chk(pie, m[8'h8c]);
    chk(pr, m[8'h92]); chk(sa, m[8'h93]); chk(ptr, m[8'h84]);
    chk(st, m[8'h83]);
  endtask
  task automatic por_model();
    foreach (m[i]) m[i] = 8'h00;
    m[8'h81] = 8'hff; m[8'h85] = 8'h3f; m[8'h86] = 8'hff; m[8'h87] = 8'hff;
    m[8'h92] = 8'hff; m[8'h83] = 8'h18; m[8'h8e] = 8'h01; pc = '0;
  endtask
  task automatic other_model(input logic dog);
    m[8'h81] = 8'hff; m[8'h85] = 8'h3f; m[8'h86] = 8'hff; m[8'h87] = 8'hff;
    m[8'h92] = 8'hff; m[8'h93] = 8'h00; m[8'h8c] = 8'h00; m[8'h8a] = 8'h00;
    pc = '0; m[8'h83] &= 8'h1f; m[8'h8b] &= 8'h01;
    if (dog) m[8'h83][4] = 1'b0;
  endtask
  task automatic core(input logic l, input logic a, input logic [7:0] v);
    @(posedge clk_i);
    ld <= l; adv <= a; lo <= v;
    @(posedge clk_i);
    ld <= 1'b0; adv <= 1'b0;
    #1;
    pc = l ? {m[8'h8a][4:0], v} : pc + 13'h1;
    chk(pcv, pc);
  endtask
  initial begin
    logic [7:0] d, k;
    foreach (wm[i]) wm[i] = 8'h00;
    wm[8'h81] = 8'hff; wm[8'h84] = 8'hff; wm[8'h85] = 8'h3f; wm[8'h86] = 8'hff;
    wm[8'h87] = 8'hff; wm[8'h8a] = 8'h1f; wm[8'h8b] = 8'hff; wm[8'h8c] = 8'hff;
    wm[8'h8e] = 8'h03; wm[8'h92] = 8'hff; wm[8'h93] = 8'hff; wm[8'h83] = 8'he7;
    por_model();
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rdall();
    for (int i = 128; i < 160; i++) begin
      k = i[7:0];
      d = rnd();
      if (k == 8'h83 || k == 8'h8c) d &= 8'h3f;
      if (k == 8'h8e) d |= 8'h01;
      if (k != 8'h82) begin wr(k, d); chk(iw, k == 8'h80); rd(k); end
      if (k == 8'h80) chk(iwd, d);
    end
    for (int i = 0; i < 12; i++) begin
      k = i[7:0];
      d = rnd() & 8'h3f;
      if (ix(k) != k) begin wr(k, d); rd(k | 8'h80); rd(k); end
      else rd(k);
    end
    wr(8'h8a, 8'hff); rd(8'h8a);
    wr(8'h82, 8'h34); chk(pcv, pc);
    core(1'b1, 1'b0, rnd());
    core(1'b0, 1'b1, 8'h00);
    wr(8'h0a, 8'h0a); chk(pcv, pc);
    @(posedge clk_i); irq <= 3'b101; sl <= 1'b1;
    @(posedge clk_i); irq <= 3'b000; sl <= 1'b0;
    m[8'h8b] |= 8'h05; m[8'h83] = (m[8'h83] | 8'h10) & 8'hf7;
    rd(8'h8b); rd(8'h83); chk(st, m[8'h83]);
    @(posedge clk_i); wd <= 1'b1;
    @(posedge clk_i); wd <= 1'b0;
    repeat (6) @(posedge clk_i);
    other_model(1'b1); rdall();
    @(posedge clk_i); ext_b <= 1'b0;
    repeat (3) @(posedge clk_i); ext_b <= 1'b1;
    repeat (8) @(posedge clk_i);
    other_model(1'b0); rdall();
    wr(8'h8e, 8'h03);
    @(posedge clk_i); bo <= 1'b1;
    repeat (3) @(posedge clk_i); bo <= 1'b0;
    repeat (8) @(posedge clk_i);
    por_model(); m[8'h8e] = 8'h02; rdall();
    @(posedge clk_i); rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i); rst_b_i <= 1'b1;
    por_model(); rdall(); chk(opt, 8'hff); chk(pa, 6'h3f);
    close_out();
  end
endmodule
